//--- xmbi_pkg.sv
// package of constants and carrier types for the external memory bus block
package xmbi_pkg;

	// ****************************************************************
	// sizes and timing
	// ****************************************************************
	localparam int ADDR_W      = 18;
	localparam int DATA_W      = 8;
	localparam int CLK_MHZ     = 200;
	// address phase and data phase lengths, in ns
	localparam int ADDR_NS     = 10;
	localparam int DATA_NS     = 10;
	localparam int ADDR_CYC    = (ADDR_NS * CLK_MHZ + 999) / 1000;
	localparam int DATA_CYC    = (DATA_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] ADDR_CNT = 4'(ADDR_CYC - 1);
	localparam logic [3:0] DATA_CNT = 4'(DATA_CYC - 1);
	// top of on-chip rom range
	localparam logic [17:0] ROM_TOP = 18'h07fff;
	// values after reset
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [7:0]  RST_UPPER  = 8'hff;
	localparam logic [1:0]  RST_STRAP  = 2'h0;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic        fetch;
		logic        write;
		logic [17:0] addr;
		logic [7:0]  wdata;
	} xmbi_req_t;

	typedef struct packed {
		logic       done;
		logic       on_chip;
		logic [7:0] rdata;
	} xmbi_rsp_t;

	typedef struct packed {
		logic       ale;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] upper;
		logic       a16;
		logic       a17;
	} xmbi_pins_t;

endpackage

//--- xmbi_sync.sv
// three-stage synchroniser for one pin input
`timescale 1ns/1ps
module xmbi_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	always_comb begin
		next_stage = {stage[1:0], pin_i};
		next_level = level_o;
		// stages two and three agree
		if (stage[2] == stage[1]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage   <= {3{RST_VAL}};
			level_o <= RST_VAL;
		end else begin
			stage   <= next_stage;
			level_o <= next_level;
		end
	end
endmodule // xmbi_sync

//--- xmbi_top.sv
// external memory bus interface: address/data mux, latch strobe, wait, fetch routing
// What this block does
// R1 - drive eighteenth address bit when its region enable is set
// R2 - drive seventeenth address bit when its region enable is set
// R3 - upper address byte on its own port, stable through the cycle
// R4 - low address then data multiplexed on one eight-bit two-way port
// R5 - latch strobe high at cycle start with low address valid
// R6 - board may latch low address with a transparent latch on strobe
// R7 - wait input held low stretches the cycle until it returns high
// R8 - wait input pulled up so a floating pin reads inactive
// R9 - strap low sends every program fetch off chip
// R10 - strap high serves fetches inside rom range on chip
// R11 - strap captured in reset and held until next reset
// R12 - parts without rom have the strap tied low on board
// R13 - active-low write strobe qualifies written data
// R14 - two region bits are static inputs, each enabling one high bit
// R15 - wait input synchronised before it stretches a cycle
`timescale 1ns/1ps
module xmbi_top (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire xmbi_pkg::xmbi_req_t req_i,
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	output xmbi_pkg::xmbi_rsp_t    rsp_o,
	input  wire logic [1:0]        region_cfg_i,
	input  wire logic              ext_access_strap_n_i,
	input  wire logic              async_wait_n_i,
	input  wire logic [7:0]        mux_addr_data_port_i,
	output logic [7:0]             mux_addr_data_port_o,
	output logic                   mux_addr_data_port_oe_n_o,
	output xmbi_pkg::xmbi_pins_t   pins_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [1:0] {IDLE, ADDR, DATA, DONE} xmbi_state_t;

	xmbi_state_t          state, next_state;
	logic [3:0]           cnt, next_cnt;
	xmbi_pkg::xmbi_req_t  cur, next_cur;
	xmbi_pkg::xmbi_rsp_t  next_rsp;
	xmbi_pkg::xmbi_pins_t next_pins;
	logic [7:0]           next_ad;
	logic                 next_oe_n;
	logic                 next_ready;
	logic                 strap_ea;
	logic                 next_strap_ea;
	logic                 wait_lvl;
	logic                 strap_lvl;
	logic                 in_reset;

	// pad pull-up modelled by the reset value of the synchroniser
	// R8 pull-up default
	// R15 wait synchroniser
	xmbi_sync #(.RST_VAL(1'b1)) u_wait_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   (async_wait_n_i),
		.level_o (wait_lvl)
	);

	// strap is a pin too; free running so reset sees a settled level
	// R11 strap synchroniser
	xmbi_sync #(.RST_VAL(1'b1)) u_strap_sync (
		.clk_i   (clk_i),
		.rst_n_i (1'b1),
		.pin_i   (ext_access_strap_n_i),
		.level_o (strap_lvl)
	);

	function automatic logic is_on_chip(input logic ea,
		input xmbi_pkg::xmbi_req_t r);
		// R9 strap low off chip
		// R10 rom range check
		return r.fetch && ea && (r.addr <= xmbi_pkg::ROM_TOP);
	endfunction

	// ****************************************************************
	// strap capture
	// ****************************************************************
	always_comb begin
		next_strap_ea = strap_ea;
		// R11 sample during reset
		if (!rst_n_i) begin
			next_strap_ea = strap_lvl;
		end
	end

	always_ff @(posedge clk_i) begin
		strap_ea <= next_strap_ea;
		in_reset <= !rst_n_i;
	end

	// ****************************************************************
	// bus cycle
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_cur   = cur;
		next_rsp   = rsp_o;
		next_pins  = pins_o;
		next_ad    = mux_addr_data_port_o;
		next_oe_n  = mux_addr_data_port_oe_n_o;
		next_ready = 1'b0;
		next_rsp.done = 1'b0;
		unique case (state)
			IDLE: begin
				next_ready = !in_reset;
				if (req_valid_i && req_ready_o) begin
					next_cur   = req_i;
					next_ready = 1'b0;
					if (is_on_chip(strap_ea, req_i)) begin
						next_rsp.done    = 1'b1;
						next_rsp.on_chip = 1'b1;
						next_state       = DONE;
					end else begin
						next_rsp.on_chip = 1'b0;
						// R3 upper address out
						next_pins.upper = req_i.addr[15:8];
						// R1 R14 high bit enable
						next_pins.a17 = region_cfg_i[1] & req_i.addr[17];
						// R2 R14 low bit enable
						next_pins.a16 = region_cfg_i[0] & req_i.addr[16];
						// R4 R5 address phase with strobe
						next_ad        = req_i.addr[7:0];
						next_oe_n      = 1'b0;
						next_pins.ale  = 1'b1;
						next_cnt       = xmbi_pkg::ADDR_CNT;
						next_state     = ADDR;
					end
				end
			end
			ADDR: begin
				if (cnt != 4'h0) begin
					next_cnt = cnt - 4'h1;
				end else begin
					next_pins.ale = 1'b0;
					next_cnt      = xmbi_pkg::DATA_CNT;
					// R4 data phase
					if (cur.write) begin
						next_ad        = cur.wdata;
						// R13 write strobe
						next_pins.wr_n = 1'b0;
					end else begin
						next_oe_n      = 1'b1;
						next_pins.rd_n = 1'b0;
					end
					next_state = DATA;
				end
			end
			DATA: begin
				if (cnt != 4'h0) begin
					next_cnt = cnt - 4'h1;
				// R7 stretch while wait low
				end else if (wait_lvl) begin
					next_rsp.rdata = mux_addr_data_port_i;
					next_rsp.done  = 1'b1;
					next_pins.rd_n = 1'b1;
					next_pins.wr_n = 1'b1;
					next_oe_n      = 1'b1;
					next_state     = DONE;
				end
			end
			DONE: begin
				next_ready = 1'b1;
				next_state = IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state                     <= IDLE;
			cnt                       <= 4'h0;
			cur                       <= '0;
			rsp_o                     <= '0;
			req_ready_o               <= 1'b0;
			mux_addr_data_port_o      <= xmbi_pkg::RST_BYTE;
			mux_addr_data_port_oe_n_o <= 1'b1;
			pins_o.ale                <= 1'b0;
			pins_o.rd_n               <= 1'b1;
			pins_o.wr_n               <= 1'b1;
			pins_o.upper              <= xmbi_pkg::RST_UPPER;
			pins_o.a16                <= 1'b0;
			pins_o.a17                <= 1'b0;
		end else begin
			state                     <= next_state;
			cnt                       <= next_cnt;
			cur                       <= next_cur;
			rsp_o                     <= next_rsp;
			req_ready_o               <= next_ready;
			mux_addr_data_port_o      <= next_ad;
			mux_addr_data_port_oe_n_o <= next_oe_n;
			pins_o                    <= next_pins;
		end
	end
endmodule // xmbi_top

//--- xmbi_top_monitor.sv
// assertion checker for the external memory bus block
`timescale 1ns/1ps
module xmbi_top_monitor (
	input wire logic                 clk_i,
	input wire logic                 rst_n_i,
	input wire xmbi_pkg::xmbi_req_t  req_i,
	input wire logic                 req_valid_i,
	input wire logic                 req_ready_o,
	input wire xmbi_pkg::xmbi_rsp_t  rsp_o,
	input wire logic [1:0]           region_cfg_i,
	input wire logic                 ext_access_strap_n_i,
	input wire logic                 async_wait_n_i,
	input wire logic [7:0]           mux_addr_data_port_o,
	input wire logic                 mux_addr_data_port_oe_n_o,
	input wire xmbi_pkg::xmbi_pins_t pins_o
);
	logic [17:0] ta;
	logic        sc;
	wire         tk = req_valid_i && req_ready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// taken address and strap seen in reset
	always_ff @(posedge clk_i) begin
		if (tk)
			ta <= req_i.addr;
		if (!rst_n_i)
			sc <= ext_access_strap_n_i;
	end
	a_strobe_low_addr: assert property (pins_o.ale |->
		!mux_addr_data_port_oe_n_o && mux_addr_data_port_o == ta[7:0])
		else $error("low address not driven under strobe");
	a_upper_addr: assert property (pins_o.ale |->
		pins_o.upper == ta[15:8]) else $error("upper address wrong");
	a_high_bits: assert property (pins_o.ale |->
		{pins_o.a17, pins_o.a16} == (region_cfg_i & ta[17:16]))
		else $error("high address bits wrong");
	a_upper_hold: assert property (!pins_o.rd_n || !pins_o.wr_n |->
		$stable(pins_o.upper)) else $error("upper moved in cycle");
	a_write_drive: assert property (!pins_o.wr_n |->
		!mux_addr_data_port_oe_n_o) else $error("write data not driven");
	a_read_float: assert property (!pins_o.rd_n |->
		mux_addr_data_port_oe_n_o) else $error("port driven in read");
	a_wait_hold: assert property ((!async_wait_n_i)[*6] |->
		!(rsp_o.done && !rsp_o.on_chip)) else $error("wait ignored");
	a_rom_fetch: assert property (tk && req_i.fetch && sc &&
		req_i.addr <= xmbi_pkg::ROM_TOP |-> ##[1:2] rsp_o.on_chip)
		else $error("rom fetch not on chip");
endmodule // xmbi_top_monitor

//--- xmbi_mem_model.sv
// external memory with address latch beside the bus block
`timescale 1ns/1ps
module xmbi_mem_model (
	input  wire logic                 clk_i,
	input  wire xmbi_pkg::xmbi_pins_t pins_i,
	input  wire logic [7:0]           ad_i,
	input  wire logic                 stall_i,
	output logic [7:0]                rd_o,
	output wire                       wait_n_o
);
	logic [7:0]  mem [0:262143];
	logic [7:0]  lat;
	logic [7:0]  last = 8'h00;
	logic [17:0] a;
	// unwritten bytes read back their own low address
	initial for (int i = 0; i < 262144; i++) mem[i] = i[7:0];
	// address latch, captured on the clock while strobe is high
	always @(posedge clk_i) if (pins_i.ale) lat <= ad_i;
	assign a = {pins_i.a17, pins_i.a16, pins_i.upper, lat};
	always @(negedge pins_i.rd_n) last = mem[a];
	always @(posedge clk_i) if (!pins_i.wr_n) mem[a] = ad_i;
	// released bus shows inverse of last byte
	assign rd_o = pins_i.rd_n ? ~last : last;
	// slow memory pulls wait low, else floats
	assign wait_n_o = stall_i ? 1'b0 : 1'bz;
endmodule // xmbi_mem_model

//--- xmbi_test.sv
// testbench for the external memory bus block
`timescale 1ns/1ps
module xmbi_test;
	logic                 clk_i = 0, rst_n_i = 0, valid = 0;
	logic                 strap = 1, stall = 0, ready, oe_n;
	logic [1:0]           cfg = 2'h3;
	logic [7:0]           ad_o, rd_d;
	int                   fail_count = 0, n_tests = 0, n;
	xmbi_pkg::xmbi_req_t  req = '0;
	xmbi_pkg::xmbi_rsp_t  rsp;
	xmbi_pkg::xmbi_pins_t pins;
	tri1                  wait_n;
	wire  [7:0]           ad_w = oe_n ? rd_d : ad_o;
	always #2.5 clk_i = ~clk_i;
	xmbi_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.req_valid_i(valid), .req_ready_o(ready), .rsp_o(rsp),
		.region_cfg_i(cfg), .ext_access_strap_n_i(strap),
		.async_wait_n_i(wait_n), .mux_addr_data_port_i(ad_w),
		.mux_addr_data_port_o(ad_o), .mux_addr_data_port_oe_n_o(oe_n),
		.pins_o(pins));
	xmbi_mem_model MEM (.clk_i(clk_i), .pins_i(pins), .ad_i(ad_o),
		.stall_i(stall), .rd_o(rd_d), .wait_n_o(wait_n));
	task automatic cmp(input logic [17:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask
	task automatic xfer(input logic f, w, input logic [17:0] a,
		input logic [7:0] d);
		int k = 0;
		req = '{f, w, a, d};
		valid = 1;
		while (ready !== 1'b1 && k++ < 40) step();
		step();
		valid = 0;
		n = 0;
		while (rsp.done !== 1'b1 && n++ < 60) step();
		cmp(rsp.done, 1);
	endtask
	task automatic do_reset();
		rst_n_i = 0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_n_i = 1;
	endtask
	task automatic t_rw();
		xfer(0, 1, 18'h3a5c3, 8'ha7);
		xfer(0, 0, 18'h3a5c3, 8'h00);
		cmp(rsp.rdata, 8'ha7);
		cmp(pins.upper, 8'ha5);
		for (int c = 0; c < 4; c++) begin
			cfg = c[1:0];
			xfer(0, 0, 18'h30000, 8'h00);
			cmp({pins.a17, pins.a16}, c[1:0]);
		end
		$display("read, write and high bits ended");
	endtask
	task automatic t_wait();
		stall = 1;
		fork
			xfer(0, 0, 18'h3a5c3, 8'h00);
			begin
				repeat (20) @(posedge clk_i);
				#1;
				stall = 0;
			end
		join
		cmp(n > 15, 1);
		cmp(rsp.rdata, 8'ha7);
		xfer(0, 1, 18'h00011, 8'h3c);
		cmp(n < 12, 1);
		$display("wait stretch ended");
	endtask
	task automatic t_route();
		xfer(1, 0, 18'h00100, 8'h00);
		cmp({rsp.on_chip, n < 2}, 2'h3);
		xfer(1, 0, 18'h08000, 8'h00);
		cmp(rsp.on_chip, 0);
		strap = 0;
		xfer(1, 0, 18'h00100, 8'h00);
		cmp(rsp.on_chip, 1);
		do_reset();
		xfer(1, 0, 18'h00100, 8'h00);
		cmp(rsp.on_chip, 0);
		$display("fetch routing ended");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		do_reset();
		t_rw();
		t_wait();
		t_route();
		report_and_stop();
	end
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule // xmbi_test
bind xmbi_top xmbi_top_monitor MON (.*);
